/* design/wdg_axi.sv */
`timescale 1ns/1ps
// axi4-lite slave front end: one write and one read at a time
module wdg_axi (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output logic [3:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  output logic rd_en,
  output logic [3:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);
  logic aw_r;
  logic w_r;
  logic [3:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  assign s_axi_awready = !aw_r && !s_axi_bvalid;
  assign s_axi_wready = !w_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_en = aw_r && w_r;
  assign wr_addr = awaddr_r;
  assign wr_data = wdata_r;
  assign wr_strb = wstrb_r;
  assign rd_en = s_axi_arvalid && s_axi_arready;
  assign rd_addr = s_axi_araddr;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_r <= 1'b0;
      w_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end else if (wr_en) begin
      aw_r <= 1'b0;
      w_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= wdg_pkg::resp_okay;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_err ? wdg_pkg::resp_slverr : wdg_pkg::resp_okay;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= wdg_pkg::resp_okay;
    end else if (rd_en) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_err ? wdg_pkg::resp_slverr : wdg_pkg::resp_okay;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // wdg_axi

/* design/wdg_pkg.sv */
package wdg_pkg;
  localparam logic [3:0] control_off = 4'h0;
  localparam logic [3:0] config_off = 4'h4;
  localparam logic [3:0] status_off = 4'h8;
  localparam logic [3:0] mask_off = 4'hc;
  localparam int activate_bit = 7;
  localparam int count_msb_bit = 6;
  localparam int count_w = 7;
  localparam int ewi_bit = 9;
  localparam int tb_lo = 7;
  localparam logic [6:0] count_reset = 7'h7f;
  localparam logic [6:0] window_reset = 7'h7f;
  localparam logic [6:0] warn_value = 7'h40;
  localparam int base_div = 4096;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage

/* design/wdg_tick.sv */
`timescale 1ns/1ps
// base prescaler then power-of-two stage; one-cycle tick out
module wdg_tick #(
  parameter int base_div = 4096
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] timebase_select,
  output logic tick
);
  // the base counter is 13 bits wide
  if (base_div < 2 || base_div > 8192) begin : g_bad_div
    $error("base_div out of range");
  end
  logic [12:0] base_r;
  logic [2:0] sub_r;
  logic base_tick;
  logic [2:0] sub_max;
  assign base_tick = (base_r == 13'(base_div - 1));
  always_comb begin
    case (timebase_select)
      2'h0: sub_max = 3'h0;
      2'h1: sub_max = 3'h1;
      2'h2: sub_max = 3'h3;
      default: sub_max = 3'h7;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      base_r <= 13'h0;
    end else if (base_tick) begin
      base_r <= 13'h0;
    end else begin
      base_r <= base_r + 13'h1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sub_r <= 3'h0;
    end else if (base_tick) begin
      if (sub_r >= sub_max) begin
        sub_r <= 3'h0;
      end else begin
        sub_r <= sub_r + 3'h1;
      end
    end
  end
  assign tick = base_tick && (sub_r >= sub_max);
endmodule // wdg_tick

/* design/window_watchdog.sv */
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
module window_watchdog (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  output logic system_reset_req
);
  logic wr_en;
  logic [3:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic [3:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;
  logic tick;
  logic activate_flag_r;
  logic [6:0] count_r;
  logic [6:0] window_r;
  logic [1:0] timebase_select_r;
  logic early_warn_irq_enable_r;
  logic early_warn_flag_r;
  logic early_warn_mask_r;
  logic system_reset_req_r;
  logic wr_ctrl;
  logic wr_cfg;
  logic wr_sts;
  logic wr_mask;
  logic reload;
  logic warn_hit;
  logic roll_hit;

  wdg_axi u_axi (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_en(),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  wdg_tick #(
    .base_div(wdg_pkg::base_div)
  ) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .timebase_select(timebase_select_r),
    .tick(tick)
  );

  // write decode; byte lane 0 carries low fields, lane 1 the upper config bits
  always_comb begin
    wr_ctrl = 1'b0;
    wr_cfg = 1'b0;
    wr_sts = 1'b0;
    wr_mask = 1'b0;
    wr_err = 1'b0;
    if (wr_addr == wdg_pkg::control_off) begin
      wr_ctrl = wr_en;
    end else if (wr_addr == wdg_pkg::config_off) begin
      wr_cfg = wr_en;
    end else if (wr_addr == wdg_pkg::status_off) begin
      wr_sts = wr_en;
    end else if (wr_addr == wdg_pkg::mask_off) begin
      wr_mask = wr_en;
    end else begin
      wr_err = 1'b1;
    end
  end

  assign reload = wr_ctrl && wr_strb[0];
  // warning as the counter steps onto 0x40, reset one tick later as it leaves it
  assign warn_hit = tick && (count_r == wdg_pkg::warn_value + 7'h1);
  assign roll_hit = tick && (count_r == wdg_pkg::warn_value);

  // activation: set-only by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      activate_flag_r <= 1'b0;
    end else if (reload && wr_data[wdg_pkg::activate_bit]) begin
      activate_flag_r <= 1'b1;
    end
  end

  // down counter free-runs; software write reloads it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= wdg_pkg::count_reset;
    end else if (reload) begin
      count_r <= wr_data[wdg_pkg::count_w-1:0];
    end else if (tick) begin
      count_r <= count_r - 7'h1;
    end
  end

  // config fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      window_r <= wdg_pkg::window_reset;
      timebase_select_r <= 2'h0;
    end else if (wr_cfg) begin
      if (wr_strb[0]) begin
        window_r <= wr_data[wdg_pkg::count_w-1:0];
      end
      if (wr_strb[0] && wr_strb[1]) begin
        timebase_select_r <= wr_data[wdg_pkg::tb_lo+1:wdg_pkg::tb_lo];
      end
    end
  end

  // interrupt enable: set-only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      early_warn_irq_enable_r <= 1'b0;
    end else if (wr_cfg && wr_strb[1] && wr_data[wdg_pkg::ewi_bit]) begin
      early_warn_irq_enable_r <= 1'b1;
    end
  end

  // warning flag: set wins over the write-zero clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      early_warn_flag_r <= 1'b0;
    end else if (warn_hit) begin
      early_warn_flag_r <= 1'b1;
    end else if (wr_sts && wr_strb[0] && !wr_data[0]) begin
      early_warn_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      early_warn_mask_r <= 1'b1;
    end else if (wr_mask && wr_strb[0]) begin
      early_warn_mask_r <= wr_data[0];
    end
  end

  // reset request, held until the system reset takes the block down
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      system_reset_req_r <= 1'b0;
    end else if (activate_flag_r && roll_hit) begin
      system_reset_req_r <= 1'b1;
    end else if (activate_flag_r && reload && (count_r > window_r)) begin
      system_reset_req_r <= 1'b1;
    end
  end

  assign system_reset_req = system_reset_req_r;
  assign irq = early_warn_flag_r && early_warn_irq_enable_r && early_warn_mask_r;

  // read decode
  always_comb begin
    rd_data = 32'h0;
    rd_err = 1'b0;
    if (rd_addr == wdg_pkg::control_off) begin
      rd_data = {24'h0, activate_flag_r, count_r};
    end else if (rd_addr == wdg_pkg::config_off) begin
      rd_data = {22'h0, early_warn_irq_enable_r, timebase_select_r, window_r};
    end else if (rd_addr == wdg_pkg::status_off) begin
      rd_data = {31'h0, early_warn_flag_r};
    end else if (rd_addr == wdg_pkg::mask_off) begin
      rd_data = {31'h0, early_warn_mask_r};
    end else begin
      rd_err = 1'b1;
    end
  end
endmodule // window_watchdog

/* dv/window_watchdog_monitor.sv */
`timescale 1ns/1ps
module window_watchdog_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq,
  input wire logic system_reset_req
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic wr_go;
  logic act_seen_r;
  logic en_seen_r;
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // remembers whether software ever set activation or warning enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_seen_r <= 1'b0;
      en_seen_r <= 1'b0;
    end else begin
      if (wr_go && s_axi_awaddr == wdg_pkg::control_off && s_axi_wdata[7]) act_seen_r <= 1'b1;
      if (wr_go && s_axi_awaddr == wdg_pkg::config_off && s_axi_wdata[9]) en_seen_r <= 1'b1;
    end
  end
  a_req_sticky: assert property (system_reset_req |=> system_reset_req)
    else $error("reset request dropped");
  a_quiet_start: assert property ($rose(aresetn) |-> !irq && !system_reset_req)
    else $error("outputs not clear after reset");
  a_req_needs_active: assert property (system_reset_req |-> act_seen_r)
    else $error("reset request while never activated");
  a_irq_needs_enable: assert property (irq |-> en_seen_r)
    else $error("interrupt without enable");
  a_clear_drops_irq: assert property (wr_go && s_axi_awaddr == wdg_pkg::status_off
    && !s_axi_wdata[0] |-> ##[1:3] !irq) else $error("interrupt stays after clear");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not released");
  a_write_latency: assert property (wr_go |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not released");
endmodule // window_watchdog_monitor

bind window_watchdog window_watchdog_monitor mon_u (.*);

/* dv/window_watchdog_test.sv */
`timescale 1ns/1ps
module window_watchdog_test;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic irq, system_reset_req;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [32:0] rq[$];
  logic [6:0] win;
  int n_errors = 0, tests_run = 0, seed = 46293, cyc = 0, t0, k;
  window_watchdog dut_u (.*);
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) cyc <= cyc + 1;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wait_hi(ref logic s, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge aclk);
      if (s === 1'b1) break;
    end
    if (i == lim) begin
      n_errors++;
      report_and_stop();
    end
  endtask
  // read answers are compared here against the oldest note when its check bit is set; write answers only against resp_okay
  always @(posedge aclk) begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
      check({30'h0, s_axi_bresp}, {30'h0, wdg_pkg::resp_okay});
    end
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && rq.size() > 0) begin
      check({30'h0, s_axi_rresp}, {30'h0, wdg_pkg::resp_okay});
      if (rq[0][32]) check(s_axi_rdata, rq[0][31:0]);
      void'(rq.pop_front());
    end
  end
  // each channel is held until the edge at which its own ready is sampled high
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int i;
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (i = 0; i < 100 && !(aw_done && w_done); i++) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    if (!(aw_done && w_done)) begin
      n_errors++;
      report_and_stop();
    end
    wait_hi(s_axi_bvalid, 100);
  endtask
  task automatic rdx(input logic [3:0] a, input logic chk, input logic [31:0] e);
    @(posedge aclk);
    rq.push_back({chk, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    wait_hi(s_axi_arready, 100);
    s_axi_arvalid <= 1'b0;
    wait_hi(s_axi_rvalid, 100);
    rd = s_axi_rdata;
  endtask
  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
    {s_axi_bready, s_axi_rready} = 2'h3;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    s_axi_wstrb = 4'hf;
    do_reset();
    rdx(wdg_pkg::control_off, 1'b1, 32'h7f);
    rdx(wdg_pkg::config_off, 1'b1, 32'h7f);
    rdx(wdg_pkg::status_off, 1'b1, 32'h0);
    rdx(wdg_pkg::mask_off, 1'b1, 32'h1);
    // inactive run through 0x40: flag only, no interrupt, no reset
    wr(wdg_pkg::control_off, 32'h41);
    rd = 32'h0;
    for (k = 0; k < 3000 && rd[0] !== 1'b1; k++) rdx(wdg_pkg::status_off, 1'b0, 32'h0);
    check({31'h0, rd[0]}, 32'h1);
    check({31'h0, irq}, 32'h0);
    repeat (4100) @(posedge aclk);
    check({31'h0, system_reset_req}, 32'h0);
    rdx(wdg_pkg::control_off, 1'b1, 32'h3f);
    wr(wdg_pkg::status_off, 32'h1);
    rdx(wdg_pkg::status_off, 1'b1, 32'h1);
    wr(wdg_pkg::status_off, 32'h0);
    rdx(wdg_pkg::status_off, 1'b1, 32'h0);
    // reload above a random window while active
    win = 7'h40 + 7'($random(seed) & 32'h1f);
    wr(wdg_pkg::control_off, 32'hff);
    check({31'h0, system_reset_req}, 32'h0);
    wr(wdg_pkg::control_off, 32'hff);
    check({31'h0, system_reset_req}, 32'h0);
    wr(wdg_pkg::config_off, {25'h0, win});
    wr(wdg_pkg::control_off, 32'hff);
    check({31'h0, system_reset_req}, 32'h1);
    do_reset();
    @(posedge aclk);
    check({31'h0, system_reset_req}, 32'h0);
    // warning then reset one tick apart at timebase 01
    wr(wdg_pkg::config_off, 32'h2ff);
    wr(wdg_pkg::control_off, 32'hc1);
    wait_hi(irq, 20000);
    t0 = cyc;
    check({31'h0, system_reset_req}, 32'h0);
    wait_hi(system_reset_req, 20000);
    check(cyc - t0, 32'd8192);
    wr(wdg_pkg::mask_off, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(wdg_pkg::mask_off, 32'h1);
    check({31'h0, irq}, 32'h1);
    wr(wdg_pkg::config_off, 32'h0);
    rdx(wdg_pkg::config_off, 1'b1, 32'h200);
    wr(wdg_pkg::control_off, 32'h7f);
    rdx(wdg_pkg::control_off, 1'b0, 32'h0);
    check({31'h0, rd[7]}, 32'h1);
    wr(wdg_pkg::status_off, 32'h0);
    check({31'h0, irq}, 32'h0);
    report_and_stop();
  end
endmodule // window_watchdog_test
